// file: sim/afb_core_monitor.sv
`timescale 1ns/1ps
module afb_core_monitor
    import afb_pkg::*;
#(
    parameter int PC_WIDTH = 21
)
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [15:0] INSTR,
    input wire logic [3:0] BANK_SELECT_REGISTER,
    input wire logic [11:0] FILE_ADDR,
    input wire logic FILE_RD,
    input wire logic FILE_WR,
    input wire logic [7:0] FILE_WDATA,
    input wire logic FLAG_N,
    input wire logic FLAG_Z,
    input wire logic [PC_WIDTH-1:0] PROGRAM_COUNTER,
    input wire logic FETCH,
    input wire logic BUSY
);
    // One clock domain, so clocking and reset are given once.
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    // The address stands together with the read strobe, so both are checked in the same phase.
    property p_cycle; $rose(FETCH) |=> !FETCH [*3] ##1 FETCH; endproperty
    a_cycle: assert property (p_cycle) else $error("cycle not four clocks");
    property p_wr; FILE_WR |-> $past(FILE_RD, 3); endproperty
    a_wr: assert property (p_wr) else $error("file write without read");
    property p_flag; FILE_WR |-> FLAG_Z == (FILE_WDATA == 8'h00) && FLAG_N == FILE_WDATA[7]; endproperty
    a_flag: assert property (p_flag) else $error("flags disagree with result");
    property p_bsr; FILE_RD && INSTR[8] |-> FILE_ADDR == {BANK_SELECT_REGISTER, INSTR[7:0]}; endproperty
    a_bsr: assert property (p_bsr) else $error("banked address wrong");
    property p_acc; FILE_RD && !INSTR[8] |-> FILE_ADDR == {(INSTR[7] ? 4'hf : 4'h0), INSTR[7:0]}; endproperty
    a_acc: assert property (p_acc) else $error("access bank wrong");
    property p_pc; $rose(BUSY) |-> PROGRAM_COUNTER ==
        $past(PROGRAM_COUNTER) + {{(PC_WIDTH-9){$past(INSTR[7])}}, $past(INSTR[7:0]), 1'b0}; endproperty
    a_pc: assert property (p_pc) else $error("branch target wrong");
    property p_busy; $rose(BUSY) |=> BUSY [*3] ##1 !BUSY; endproperty
    a_busy: assert property (p_busy) else $error("flush cycle length wrong");
    property p_nord; BUSY |-> !FILE_RD; endproperty
    a_nord: assert property (p_nord) else $error("flushed cycle read file");
endmodule
bind afb_core afb_core_monitor #(.PC_WIDTH(PC_WIDTH)) afb_core_monitor_i (.CLK(CLK), .RESET(RESET), .INSTR(INSTR),
    .BANK_SELECT_REGISTER(BANK_SELECT_REGISTER), .FILE_ADDR(FILE_ADDR), .FILE_RD(FILE_RD), .FILE_WR(FILE_WR),
    .FILE_WDATA(FILE_WDATA), .FLAG_N(FLAG_N), .FLAG_Z(FLAG_Z), .PROGRAM_COUNTER(PROGRAM_COUNTER),
    .FETCH(FETCH), .BUSY(BUSY));

// file: sim/and_file_and_carry_branch_exec_tb.sv
`timescale 1ns/1ps
module and_file_and_carry_branch_exec_tb import afb_pkg::*;;
    logic CLK = 1'b0;
    logic RESET = 1'b1;
    logic [15:0] INSTR = 16'h0000;
    logic [7:0] FILE_RDATA = 8'hff;
    logic [3:0] BANK_SELECT_REGISTER = 4'h5;
    logic CARRY = 1'b0;
    logic [11:0] FILE_ADDR;
    logic [7:0] FILE_WDATA, WORKING_ACCUMULATOR;
    logic [20:0] PROGRAM_COUNTER;
    logic FILE_RD, FILE_WR, FLAG_N, FLAG_Z, FETCH, BUSY;
    logic rd_q2 = 1'b0;
    int n_mismatch = 0;
    int samples_checked = 0;
    // Core under test.
    afb_core afb_core_i (.CLK(CLK), .RESET(RESET), .INSTR(INSTR), .FILE_RDATA(FILE_RDATA),
        .BANK_SELECT_REGISTER(BANK_SELECT_REGISTER), .CARRY(CARRY), .FILE_ADDR(FILE_ADDR), .FILE_RD(FILE_RD),
        .FILE_WR(FILE_WR), .FILE_WDATA(FILE_WDATA), .WORKING_ACCUMULATOR(WORKING_ACCUMULATOR),
        .FLAG_N(FLAG_N), .FLAG_Z(FLAG_Z), .PROGRAM_COUNTER(PROGRAM_COUNTER), .FETCH(FETCH), .BUSY(BUSY));
    // Free-running 50 MHz clock.
    initial forever #10 CLK = ~CLK;
    // Compare one value and count it.
    task chk(input logic [20:0] g, input logic [20:0] e);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %0t %h %h", $time, g, e);
        end
    endtask
    // One instruction lasts four clocks; it returns in the first phase of the next one.
    task step(input logic [15:0] i, input logic c);
        INSTR = i;
        CARRY = c;
        @(posedge CLK);
        #1 rd_q2 = FILE_RD;
        repeat (3) @(posedge CLK);
        #1;
    endtask
    // The accumulator starts at zero, so every result is zero; the address path carries the interest.
    task and_to_acc;
        step({AFB_OP_AND_FILE, 2'b00, 8'h85}, 1'b0);
        chk(WORKING_ACCUMULATOR, 21'h0);
        chk({FLAG_N, FLAG_Z}, 21'h1);
        chk(FILE_WR, 21'h0);
        chk(FILE_ADDR, 21'hf85);
        chk(PROGRAM_COUNTER, 21'h2);
        chk(rd_q2, 21'h1);
        chk(FETCH, 21'h1);
    endtask
    task and_to_file;
        step({AFB_OP_AND_FILE, 2'b11, 8'h12}, 1'b1);
        chk(FILE_WR, 21'h1);
        chk(FILE_WDATA, 21'h0);
        chk(FILE_ADDR, 21'h512);
        chk(PROGRAM_COUNTER, 21'h4);
        chk(rd_q2, 21'h1);
    endtask
    task branch_not_taken;
        step({AFB_OP_BR_CARRY, 8'h7f}, 1'b0);
        chk(PROGRAM_COUNTER, 21'h6);
        chk(rd_q2, 21'h0);
        chk({BUSY, FILE_WR}, 21'h0);
    endtask
    // Most negative offset wraps below zero; the flushed write must not happen.
    task branch_taken_flush;
        step({AFB_OP_BR_CARRY, 8'h80}, 1'b1);
        chk(PROGRAM_COUNTER, 21'h1fff08);
        chk(BUSY, 21'h1);
        step({AFB_OP_AND_FILE, 2'b10, 8'h10}, 1'b0);
        chk({BUSY, FILE_WR}, 21'h0);
        chk(rd_q2, 21'h0);
        chk(PROGRAM_COUNTER, 21'h1fff0a);
        step({AFB_OP_BR_CARRY, 8'h05}, 1'b1);
        chk(PROGRAM_COUNTER, 21'h1fff16);
        chk({FLAG_N, FLAG_Z}, 21'h1);
    endtask
    task summarize;
        if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Reset for two clocks, then run the scenarios back to back.
    initial begin
        repeat (2) @(posedge CLK);
        #1 RESET = 1'b0;
        and_to_acc();
        and_to_file();
        branch_not_taken();
        branch_taken_flush();
        summarize();
    end
endmodule

// file: verilog/afb_core.sv
`timescale 1ns/1ps
// Operation
// - AND-with-file opcode 000101: AND accumulator with file, set only negative and zero.
// - Bank bit 0 uses the fixed access bank; 1 uses the bank-select register.
// - AND-with-file is one word, one cycle: decode, read, process, write.
// - Branch-on-carry opcode 0xe2: if carry, counter becomes counter plus 2 plus 2n.
// - Offset is signed -128..127, doubled, added to the already incremented counter.
// - Taken branch: counter written in fourth phase, then a no-operation cycle.
module afb_core
    import afb_pkg::*;
#(
    parameter int PC_WIDTH = 21
)
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [15:0] INSTR,
    input wire logic [7:0] FILE_RDATA,
    input wire logic [3:0] BANK_SELECT_REGISTER,
    input wire logic CARRY,
    output logic [11:0] FILE_ADDR,
    output logic FILE_RD,
    output logic FILE_WR,
    output logic [7:0] FILE_WDATA,
    output logic [7:0] WORKING_ACCUMULATOR,
    output logic FLAG_N,
    output logic FLAG_Z,
    output logic [PC_WIDTH-1:0] PROGRAM_COUNTER,
    output logic FETCH,
    output logic BUSY
);
    afb_phase_type phase;
    logic [15:0] instr_ff;
    logic [7:0] operand_ff;
    logic [7:0] result_ff;
    logic flush_ff;
    logic is_and;
    logic is_bc;
    logic [11:0] nxt_addr;
    logic [PC_WIDTH-1:0] nxt_target;
    logic [PC_WIDTH-1:0] offset_ext;
    logic rd_request;
    logic taken;

    afb_phase_gen u_phase (
        .clk(CLK),
        .reset(RESET),
        .phase(phase)
    );

    // A flushed cycle decodes nothing, so the fetched word never acts twice.
    assign is_and = !flush_ff && (instr_ff[AFB_OP6_MSB:AFB_OP6_LSB] == AFB_OP_AND_FILE);
    assign is_bc = !flush_ff && (instr_ff[AFB_OP6_MSB:AFB_OP8_LSB] == AFB_OP_BR_CARRY);

    // Address forming from the word on the bus in the decode phase. Taking it from the bus
    // rather than from the latch lets the address and the read strobe stand together in the
    // read phase, so a plain combinational file answers in time for the operand capture.
    always_comb begin
        if (INSTR[AFB_BANK_BIT]) begin
            nxt_addr = {BANK_SELECT_REGISTER, INSTR[AFB_SIGN_BIT:AFB_FILE_LSB]};
        end else if (INSTR[AFB_SIGN_BIT:AFB_FILE_LSB] < AFB_ACCESS_SPLIT) begin
            nxt_addr = {AFB_ACCESS_LOW_BANK, INSTR[AFB_SIGN_BIT:AFB_FILE_LSB]};
        end else begin
            nxt_addr = {AFB_ACCESS_HIGH_BANK, INSTR[AFB_SIGN_BIT:AFB_FILE_LSB]};
        end
    end

    // A read is asked for only by an AND-with-file word outside a flushed cycle.
    assign rd_request = (INSTR[AFB_OP6_MSB:AFB_OP6_LSB] == AFB_OP_AND_FILE) && !BUSY;

    // The branch is taken only when the decoded word is a branch and carry is set.
    assign taken = is_bc && CARRY;

    // Sign-extended offset, doubled, added to the incremented counter.
    assign offset_ext = PC_WIDTH'({{(PC_WIDTH-AFB_FILE_WIDTH){instr_ff[AFB_SIGN_BIT]}},
        instr_ff[AFB_SIGN_BIT:AFB_FILE_LSB]});
    assign nxt_target = PC_WIDTH'(PROGRAM_COUNTER + (offset_ext << 1));

    // Instruction latch in the decode phase; the word is held for the cycle.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            instr_ff <= AFB_WORD_ZERO;
        end else if (phase == AFB_Q1) begin
            instr_ff <= INSTR;
        end
    end

    // Fetch strobe for the next word; the counter already points at it.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            FETCH <= 1'b0;
        end else begin
            FETCH <= (phase == AFB_Q4);
        end
    end

    // Program counter: step past the word in the decode phase, load the target in the write
    // phase. The step comes first, so the offset is added to the incremented value.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            PROGRAM_COUNTER <= PC_WIDTH'(AFB_PC_RESET);
        end else if (phase == AFB_Q1) begin
            PROGRAM_COUNTER <= PC_WIDTH'(PROGRAM_COUNTER + PC_WIDTH'(AFB_PC_STEP));
        end else if (phase == AFB_Q4 && taken) begin
            PROGRAM_COUNTER <= nxt_target;
        end
    end

    // Taken branch squashes the next cycle, which becomes a no-operation.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            flush_ff <= 1'b0;
        end else if (phase == AFB_Q4) begin
            flush_ff <= taken;
        end
    end

    // The busy flag shows the squashed cycle outside; it holds for all four phases, so a
    // word presented during it is ignored however its opcode decodes.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            BUSY <= 1'b0;
        end else if (phase == AFB_Q4) begin
            BUSY <= taken;
        end
    end

    // Read strobe for the read phase; a flushed cycle must not touch the file.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            FILE_RD <= 1'b0;
        end else begin
            FILE_RD <= (phase == AFB_Q1) && rd_request;
        end
    end

    // The address loads with the strobe and then holds, so it still names the same register
    // when the result goes back in the write phase.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            FILE_ADDR <= AFB_ADDR_ZERO;
        end else if (phase == AFB_Q1 && rd_request) begin
            FILE_ADDR <= nxt_addr;
        end
    end

    // Operand capture at the end of the read phase, while address and strobe still stand.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            operand_ff <= AFB_BYTE_ZERO;
        end else if (phase == AFB_Q2) begin
            operand_ff <= FILE_RDATA;
        end
    end

    // The AND itself is done in the process phase.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            result_ff <= AFB_BYTE_ZERO;
        end else if (phase == AFB_Q3) begin
            result_ff <= WORKING_ACCUMULATOR & operand_ff;
        end
    end

    // Flags follow the AND result only; the branch leaves them alone.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            FLAG_N <= 1'b0;
            FLAG_Z <= 1'b0;
        end else if (phase == AFB_Q4 && is_and) begin
            FLAG_N <= result_ff[AFB_SIGN_BIT];
            FLAG_Z <= (result_ff == AFB_BYTE_ZERO);
        end
    end

    // Accumulator destination in the write phase.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            WORKING_ACCUMULATOR <= AFB_BYTE_ZERO;
        end else if (phase == AFB_Q4 && is_and && !instr_ff[AFB_DEST_BIT]) begin
            WORKING_ACCUMULATOR <= result_ff;
        end
    end

    // File write strobe: a single clock, right after the write phase.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            FILE_WR <= 1'b0;
        end else begin
            FILE_WR <= (phase == AFB_Q4) && is_and && instr_ff[AFB_DEST_BIT];
        end
    end

    // Write data holds after the strobe, so a slow file may latch it late.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            FILE_WDATA <= AFB_BYTE_ZERO;
        end else if (phase == AFB_Q4 && is_and && instr_ff[AFB_DEST_BIT]) begin
            FILE_WDATA <= result_ff;
        end
    end
endmodule

// file: verilog/afb_phase_gen.sv
`timescale 1ns/1ps
module afb_phase_gen
    import afb_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    output afb_phase_type phase
);
    afb_phase_type phase_ff;
    afb_phase_type nxt_phase;

    // The phase ring advances one step per clock and wraps after the fourth.
    always_comb begin
        unique case (phase_ff)
            AFB_Q1: nxt_phase = AFB_Q2;
            AFB_Q2: nxt_phase = AFB_Q3;
            AFB_Q3: nxt_phase = AFB_Q4;
            AFB_Q4: nxt_phase = AFB_Q1;
            default: nxt_phase = AFB_Q1;
        endcase
    end

    // Reset parks the ring at the decode phase.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            phase_ff <= AFB_Q1;
        end else begin
            phase_ff <= nxt_phase;
        end
    end

    assign phase = phase_ff;
endmodule

// file: verilog/afb_pkg.sv
package afb_pkg;
    // Opcode fields of the two decoded instructions.
    localparam logic [5:0] AFB_OP_AND_FILE = 6'h05;
    localparam logic [7:0] AFB_OP_BR_CARRY = 8'he2;
    localparam int AFB_OP6_MSB = 15;
    localparam int AFB_OP6_LSB = 10;
    localparam int AFB_OP8_LSB = 8;
    localparam int AFB_DEST_BIT = 9;
    localparam int AFB_BANK_BIT = 8;
    // File address and branch offset share the low byte; its top bit is the sign.
    localparam int AFB_SIGN_BIT = 7;
    localparam int AFB_FILE_LSB = 0;
    localparam int AFB_FILE_WIDTH = 8;
    // Access bank split: low addresses hit bank 0, high ones the top bank.
    localparam logic [7:0] AFB_ACCESS_SPLIT = 8'h80;
    localparam logic [3:0] AFB_ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] AFB_ACCESS_HIGH_BANK = 4'hf;
    localparam logic [20:0] AFB_PC_STEP = 21'h000002;
    localparam logic [20:0] AFB_PC_RESET = 21'h000000;
    localparam logic [7:0] AFB_BYTE_ZERO = 8'h00;
    localparam logic [15:0] AFB_WORD_ZERO = 16'h0000;
    localparam logic [11:0] AFB_ADDR_ZERO = 12'h000;
    // Four phases of one instruction cycle, one-hot.
    typedef enum logic [3:0] {
        AFB_Q1 = 4'b0001,
        AFB_Q2 = 4'b0010,
        AFB_Q3 = 4'b0100,
        AFB_Q4 = 4'b1000
    } afb_phase_type;
endpackage
